/* logic/evpr_resolver.sv */
// Exception arbiter, vector fetch sequencer and Wishbone register slave
`timescale 1ns/1ps
module evpr_resolver
  import evpr_pkg::*;
#(
  parameter logic [29:0] IRQ_PRESENT = IRQ_PRESENT_DFLT
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic i_wb_priv,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Exception sources
  input wire logic [NUM_IRQ-1:0] i_irq,
  input wire logic i_nmi,
  input wire logic i_hard_fault,
  input wire logic i_mem_fault,
  input wire logic i_bus_fault,
  input wire logic i_usage_fault,
  input wire logic i_svc_req,
  input wire logic i_dbg_req,
  // Core side
  output logic o_fetch_req,
  output logic [31:0] o_fetch_addr,
  input wire logic i_fetch_ack,
  input wire logic [31:0] i_fetch_data,
  input wire logic i_handler_done,
  output logic o_take,
  output logic [5:0] o_exc_num,
  output logic [31:0] o_handler_addr,
  output logic [31:0] o_sp_init
);

  evpr_state_t state_reg;
  logic [31:0] vbase_reg;
  logic [NUM_IRQ-1:0] en_reg;
  logic [NUM_EXC-1:0] pend_reg;
  logic [NUM_EXC-1:0] pend_next;
  logic [NUM_EXC-1:0] act_reg;
  logic [NUM_EXC-1:0] act_next;
  logic [2:0] pri_reg [NUM_EXC];
  logic [3:0] lvl [NUM_EXC];
  logic [5:0] sel_reg;
  logic [NUM_IRQ-1:0] irq_meta;
  logic [NUM_IRQ-1:0] irq_sync;
  logic nmi_meta;
  logic nmi_sync;

  // Configurable exceptions own a priority field; the rest are fixed
  function automatic logic is_cfg(input logic [5:0] n);
    return (n == EXC_MEM) || (n == EXC_BUS) || (n == EXC_USAGE) || (n == EXC_SVC) ||
      (n == EXC_DBG) || (n == EXC_PENDABLE_SERVICE_REQUEST) || (n == EXC_SYSTICK) || (n >= EXC_IRQ_BASE);
  endfunction

  // Handler word lives at base plus four per exception number
  function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [5:0] n);
    return base + {24'h000000, n, 2'b00}; // RULE19 RULE3 RULE4
  endfunction

  // Most urgent member of a set; strict compare keeps the lowest number on ties
  function automatic logic [6:0] pick_best(input logic [NUM_EXC-1:0] m);
    logic [3:0] best;
    logic [5:0] num;
    logic hit;
    best = LVL_NONE;
    num = 6'h00;
    hit = 1'b0;
    for (int i = 0; i < NUM_EXC; i++) begin
      if (m[i] && (lvl[i] < best)) begin // RULE9 RULE13
        best = lvl[i];
        num = 6'(i);
        hit = 1'b1;
      end
    end
    return {hit, num};
  endfunction

  // Urgency level per exception number
  always_comb begin
    for (int i = 0; i < NUM_EXC; i++) begin
      if (6'(i) == EXC_NMI) begin
        lvl[i] = LVL_NMI; // RULE17 RULE12
      end else if (6'(i) == EXC_HARD) begin
        lvl[i] = LVL_HARD; // RULE18 RULE12
      end else begin
        lvl[i] = LVL_CFG_OFS + {1'b0, pri_reg[i]}; // RULE10 RULE11
      end
    end
  end

  // Arbitration against the running handler
  wire [NUM_EXC-1:0] en_mask = {en_reg, 16'hFFFF}; // NMI has no enable bit
  wire [NUM_EXC-1:0] eligible = pend_reg & en_mask;
  logic [6:0] best_pend;
  logic [6:0] best_act;
  // Searched in a process so that a priority write alone also re-runs the search
  always_comb begin
    best_pend = pick_best(eligible);
    best_act = pick_best(act_reg);
  end
  wire best_hit = best_pend[6];
  wire [5:0] best_num = best_pend[5:0];
  wire [3:0] best_lvl = lvl[best_num];
  wire [5:0] run_num = best_act[5:0];
  wire [3:0] run_lvl = best_act[6] ? lvl[run_num] : LVL_NONE;
  wire preempt = best_hit && (best_lvl < run_lvl); // RULE14 RULE15
  wire fetch_done = (state_reg == ST_FETCH) && i_fetch_ack;

  // Bus decode
  wire wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire wb_wr = wb_req && i_wb_we;
  wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [31:0] wdat = i_wb_dat & wmask;
  wire [7:0] pri_off = i_wb_adr - ADR_PRI_BASE;
  wire [5:0] pri_idx = pri_off[7:2];
  wire pri_hit = (i_wb_adr >= ADR_PRI_BASE) && (pri_off[7:2] < 6'(NUM_EXC));
  wire [31:0] vbase_next = ((vbase_reg & ~wmask) | wdat) & VBASE_MASK; // RULE7 RULE8
  wire [31:0] status_word = {20'h00000, run_lvl, 2'b00, run_num};

  // Read multiplexer; unmapped offsets read as zero
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h00000000;
    case (i_wb_adr)
      ADR_VBASE: rd_data = vbase_reg;
      ADR_ENABLE: rd_data = {2'b00, en_reg};
      ADR_PEND_SET: rd_data = {2'b00, pend_reg[NUM_EXC-1:16]};
      ADR_ACTIVE: rd_data = {2'b00, act_reg[NUM_EXC-1:16]};
      ADR_STATUS: rd_data = status_word;
      ADR_SYS_PEND: rd_data = {30'h00000000, pend_reg[EXC_SYSTICK], pend_reg[EXC_PENDABLE_SERVICE_REQUEST]};
      default: rd_data = (pri_hit && is_cfg(pri_idx)) ? {29'h00000000, pri_reg[pri_idx]} : 32'h00000000;
    endcase
  end

  // Pending update: every set term is applied after the clears, so a set wins
  always_comb begin
    pend_next = pend_reg;
    if (fetch_done) begin
      pend_next[sel_reg] = 1'b0;
    end
    if (wb_wr && (i_wb_adr == ADR_PEND_CLR)) begin
      pend_next[NUM_EXC-1:16] = pend_next[NUM_EXC-1:16] & ~wdat[NUM_IRQ-1:0];
    end
    if (wb_wr && (i_wb_adr == ADR_SYS_PEND)) begin
      pend_next[EXC_PENDABLE_SERVICE_REQUEST] = pend_next[EXC_PENDABLE_SERVICE_REQUEST] | wdat[0];
      pend_next[EXC_SYSTICK] = pend_next[EXC_SYSTICK] | wdat[1];
    end
    if (wb_wr && (i_wb_adr == ADR_PEND_SET)) begin
      pend_next[NUM_EXC-1:16] = pend_next[NUM_EXC-1:16] | wdat[NUM_IRQ-1:0];
    end
    pend_next[NUM_EXC-1:16] = pend_next[NUM_EXC-1:16] | (irq_sync & IRQ_PRESENT); // RULE2 RULE20 RULE16
    pend_next[EXC_NMI] = pend_next[EXC_NMI] | nmi_sync; // RULE17
    pend_next[EXC_HARD] = pend_next[EXC_HARD] | i_hard_fault;
    pend_next[EXC_MEM] = pend_next[EXC_MEM] | i_mem_fault;
    pend_next[EXC_BUS] = pend_next[EXC_BUS] | i_bus_fault;
    pend_next[EXC_USAGE] = pend_next[EXC_USAGE] | i_usage_fault;
    pend_next[EXC_SVC] = pend_next[EXC_SVC] | i_svc_req;
    pend_next[EXC_DBG] = pend_next[EXC_DBG] | i_dbg_req;
  end

  // Active set: the most urgent active handler is the one running
  always_comb begin
    act_next = act_reg;
    if (i_handler_done && best_act[6]) begin
      act_next[run_num] = 1'b0;
    end
    if (fetch_done) begin
      act_next[sel_reg] = 1'b1;
    end
  end

  // Pin synchronisers for asynchronous sources
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      irq_meta <= '0;
      irq_sync <= '0;
      nmi_meta <= 1'b0;
      nmi_sync <= 1'b0;
    end else if (i_ce) begin
      irq_meta <= i_irq;
      irq_sync <= irq_meta;
      nmi_meta <= i_nmi;
      nmi_sync <= nmi_meta;
    end
  end

  // Bus slave: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      vbase_reg <= VBASE_RST; // RULE6
      en_reg <= '0;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
      o_wb_dat <= wb_req ? rd_data : 32'h00000000;
      if (wb_wr && i_wb_priv && (i_wb_adr == ADR_VBASE)) begin
        vbase_reg <= vbase_next; // RULE7 RULE8
      end
      if (wb_wr && (i_wb_adr == ADR_ENABLE)) begin
        en_reg <= (en_reg & ~wmask[NUM_IRQ-1:0]) | wdat[NUM_IRQ-1:0];
      end
    end
  end

  // Priority fields; fixed exceptions ignore writes
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      for (int i = 0; i < NUM_EXC; i++) begin
        pri_reg[i] <= PRI_RST; // RULE1
      end
    end else if (i_ce && wb_wr && pri_hit && is_cfg(pri_idx) && i_wb_sel[0]) begin
      pri_reg[pri_idx] <= i_wb_dat[2:0]; // RULE10 RULE11
    end
  end

  // Exception state
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      pend_reg <= '0;
      act_reg <= '0;
    end else if (i_ce) begin
      pend_reg <= pend_next;
      act_reg <= act_next;
    end
  end

  // Vector fetch sequencer: stack word, reset handler, then exceptions
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_reg <= ST_SP;
      sel_reg <= 6'h00;
      o_fetch_req <= 1'b1;
      o_fetch_addr <= VBASE_RST;
      o_take <= 1'b0;
      o_exc_num <= 6'h00;
      o_handler_addr <= 32'h00000000;
      o_sp_init <= 32'h00000000;
    end else if (i_ce) begin
      o_take <= 1'b0;
      case (state_reg)
        ST_SP: begin
          if (i_fetch_ack) begin
            o_sp_init <= i_fetch_data; // RULE4
            o_fetch_addr <= vec_addr(vbase_reg, EXC_RESET);
            state_reg <= ST_RESET_PC;
          end
        end
        ST_RESET_PC: begin
          if (i_fetch_ack) begin
            o_fetch_req <= 1'b0;
            o_handler_addr <= i_fetch_data;
            o_exc_num <= EXC_RESET;
            o_take <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (preempt) begin // RULE14 RULE15
            sel_reg <= best_num;
            o_fetch_req <= 1'b1;
            o_fetch_addr <= vec_addr(vbase_reg, best_num); // RULE19
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (i_fetch_ack) begin
            o_fetch_req <= 1'b0;
            o_handler_addr <= i_fetch_data; // Bit zero kept as software wrote it
            o_exc_num <= sel_reg;
            o_take <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_vbase_aligned: assert property (vbase_reg[7:0] == 8'h00 && vbase_reg[31:30] == 2'b00) // RULE8
    else $error("vector base not aligned or out of range");
  a_vbase_reset: assert property ($past(i_srst) |-> vbase_reg == 32'h00000000) // RULE6
    else $error("vector base not zero after reset");
  a_pri_reset: assert property ($past(i_srst) |-> pri_reg[16] == 3'h0 && pri_reg[14] == 3'h0) // RULE1
    else $error("priority not zero after reset");
  a_fetch_addr_form: assert property ($rose(state_reg == ST_FETCH) |-> o_fetch_addr == vbase_reg + {sel_reg, 2'b00}) // RULE19
    else $error("fetch address not base plus four times number");
  a_equal_no_preempt: assert property (i_ce && state_reg == ST_IDLE && best_hit && best_lvl >= run_lvl |=> state_reg == ST_IDLE) // RULE15
    else $error("equal or lower priority preempted");
  a_preempt_starts: assert property (i_ce && state_reg == ST_IDLE && preempt |=> state_reg == ST_FETCH && sel_reg == $past(best_num)) // RULE14
    else $error("urgent exception did not start fetch");
  a_nmi_first: assert property (pend_reg[2] |-> best_num == EXC_NMI && best_hit) // RULE17
    else $error("pending NMI not selected");
  a_hard_over_cfg: assert property (pend_reg[3] && !pend_reg[2] |-> best_num == EXC_HARD) // RULE18
    else $error("hard fault lost to configurable exception");
  a_irq_maps: assert property (i_ce && irq_sync[0] |=> pend_reg[16]) // RULE2
    else $error("interrupt 0 did not pend exception 16");
  a_sp_word_zero: assert property (i_ce && state_reg == ST_SP && i_fetch_ack |=> o_sp_init == $past(i_fetch_data)) // RULE4
    else $error("stack word not captured");

  c_take: cover property (o_take && o_exc_num >= EXC_IRQ_BASE);
  c_nested: cover property (o_take && $countones(act_reg) > 1);
  c_held_pending: cover property (state_reg == ST_IDLE && best_hit && !preempt);

endmodule

/* inc/evpr_pkg.sv */
// Constants, register map and state type for the exception priority vector resolver
// Behaviour
// RULE1: Configurable priorities reset to zero
// RULE2: Interrupt n is exception n+16, bit n
// RULE3: SysTick slot 15, service request 14, interrupts follow
// RULE4: Word zero is stack pointer, others handlers
// RULE5: Software sets handler address bit zero
// RULE6: Reset forces vector base to zero
// RULE7: Privileged write relocates base within range
// RULE8: Base aligned to 256 bytes
// RULE9: Smaller priority value is more urgent
// RULE10: Reset, hard fault, NMI fixed; others programmable
// RULE11: Configurable priority is three bits
// RULE12: Fixed negative priorities always win
// RULE13: Equal priority: lowest exception number wins
// RULE14: Strictly more urgent exception preempts handler
// RULE15: Equal priority never preempts running handler
// RULE16: Non-preempting exception stays pending
// RULE17: NMI always enabled, level minus two
// RULE18: Hard fault level minus one
// RULE19: Fetch address is base plus four times number
// RULE20: Unconnected interrupt slots never pend from hardware
package evpr_pkg;
  localparam int unsigned NUM_IRQ = 30;
  localparam int unsigned NUM_EXC = 46;
  // Register byte offsets
  localparam logic [7:0] ADR_VBASE = 8'h00;
  localparam logic [7:0] ADR_ENABLE = 8'h04;
  localparam logic [7:0] ADR_PEND_SET = 8'h08;
  localparam logic [7:0] ADR_PEND_CLR = 8'h0C;
  localparam logic [7:0] ADR_ACTIVE = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_SYS_PEND = 8'h18;
  localparam logic [7:0] ADR_PRI_BASE = 8'h40;
  // Exception numbers
  localparam logic [5:0] EXC_RESET = 6'h01;
  localparam logic [5:0] EXC_NMI = 6'h02;
  localparam logic [5:0] EXC_HARD = 6'h03;
  localparam logic [5:0] EXC_MEM = 6'h04;
  localparam logic [5:0] EXC_BUS = 6'h05;
  localparam logic [5:0] EXC_USAGE = 6'h06;
  localparam logic [5:0] EXC_SVC = 6'h0B;
  localparam logic [5:0] EXC_DBG = 6'h0C;
  localparam logic [5:0] EXC_PENDABLE_SERVICE_REQUEST = 6'h0E;
  localparam logic [5:0] EXC_SYSTICK = 6'h0F;
  localparam logic [5:0] EXC_IRQ_BASE = 6'h10;
  // Internal urgency levels: printed priority plus three
  localparam logic [3:0] LVL_NMI = 4'h1;
  localparam logic [3:0] LVL_HARD = 4'h2;
  localparam logic [3:0] LVL_CFG_OFS = 4'h3;
  localparam logic [3:0] LVL_NONE = 4'hF;
  // Reset values and masks
  localparam logic [2:0] PRI_RST = 3'h0;
  localparam logic [31:0] VBASE_RST = 32'h00000000;
  localparam logic [31:0] VBASE_MASK = 32'h3FFFFF00;
  localparam logic [29:0] IRQ_PRESENT_DFLT = 30'h3FFC01FF;
  typedef enum logic [1:0] {
    ST_SP = 2'b00,
    ST_RESET_PC = 2'b01,
    ST_IDLE = 2'b10,
    ST_FETCH = 2'b11
  } evpr_state_t;
endpackage

/* verification/evpr_core_model.sv */
// Core-side model: answers vector word reads after a set wait
`timescale 1ns/1ps
module evpr_core_model #(
  parameter logic [31:0] VEC_OFS = 32'h08000001
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Fetch link
  input wire logic i_fetch_req,
  input wire logic [31:0] i_fetch_addr,
  input wire logic [3:0] i_wait,
  output logic o_fetch_ack,
  output logic [31:0] o_fetch_data
);
  logic [3:0] wait_reg;
  // Data toggles outside the ack cycle so a late sample never matches by luck
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_fetch_ack <= 1'b0;
      o_fetch_data <= 32'hFFFFFFFF;
      wait_reg <= 4'h0;
    end else if (o_fetch_ack) begin
      o_fetch_ack <= 1'b0;
      o_fetch_data <= ~o_fetch_data;
      wait_reg <= 4'h0;
    end else if (i_fetch_req && wait_reg >= i_wait) begin
      o_fetch_ack <= 1'b1;
      o_fetch_data <= i_fetch_addr + VEC_OFS;
    end else begin
      o_fetch_data <= ~o_fetch_data;
      wait_reg <= i_fetch_req ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule

/* verification/exception_priority_vector_resolver_tb.sv */
// Self-checking bench for the exception resolver
`timescale 1ns/1ps
module exception_priority_vector_resolver_tb;
  import evpr_pkg::*;
  localparam logic [31:0] OFS = 32'h08000001;
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, priv = 1'b1, ce = 1'b1;
  logic nmi = 1'b0, hard = 1'b0, svc = 1'b0, done = 1'b0, ack, freq, fack, take;
  logic [3:0] sel = 4'h0, fwait = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [5:0] num;
  logic [29:0] irq = 30'h0;
  logic [31:0] wdat = 32'h0, rdat, wbq, fdat, faddr, haddr, sp, base = 32'h0;
  int miscompares = 0, total_checks = 0, cycles = 0;
  // Clock and hang guard
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  evpr_resolver i_dut (.i_core_clk(clk), .i_srst(srst), .i_ce(ce), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .i_wb_priv(priv), .o_wb_dat(wbq),
    .o_wb_ack(ack), .i_irq(irq), .i_nmi(nmi), .i_hard_fault(hard), .i_mem_fault(1'b0), .i_bus_fault(1'b0),
    .i_usage_fault(1'b0), .i_svc_req(svc), .i_dbg_req(1'b0), .o_fetch_req(freq), .o_fetch_addr(faddr),
    .i_fetch_ack(fack), .i_fetch_data(fdat), .i_handler_done(done), .o_take(take), .o_exc_num(num),
    .o_handler_addr(haddr), .o_sp_init(sp));
  evpr_core_model #(.VEC_OFS(OFS)) i_core (.i_core_clk(clk), .i_srst(srst), .i_fetch_req(freq),
    .i_fetch_addr(faddr), .i_wait(fwait), .o_fetch_ack(fack), .o_fetch_data(fdat));
  // Shared checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic p = 1'b1);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel, priv} <= {2'b11, w, a, d, 4'hF, p};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = wbq;
    {cyc, stb, we, sel, priv} <= 8'h01;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  // Waits for an entry, then checks number and handler address
  task automatic take_chk(input logic [5:0] n_exp);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (take !== 1'b1 && n < 200);
    chk({31'h0, take}, 32'h1);
    chk({26'h0, num}, {26'h0, n_exp});
    chk(haddr, base + {24'h0, n_exp, 2'b00} + OFS);
  endtask
  task automatic retire();
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      chk({31'h0, take}, 32'h0);
    end
  endtask
  // Scenarios
  task automatic t_reset();
    take_chk(EXC_RESET);
    chk(sp, OFS);
    retire();
    rd_chk(ADR_VBASE, 32'h0);
    rd_chk(ADR_PRI_BASE + 8'h40, 32'h0);
    rd_chk(ADR_PRI_BASE + 8'h10, 32'h0);
  endtask
  task automatic t_base();
    wb(1'b1, ADR_VBASE, 32'h00001000, 1'b0);
    rd_chk(ADR_VBASE, 32'h0);
    wb(1'b1, ADR_VBASE, 32'h123456AB);
    rd_chk(ADR_VBASE, 32'h12345600);
    wb(1'b1, 8'h3C, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h0);
    base = 32'h12345600;
    wb(1'b1, ADR_PRI_BASE + 8'h40, 32'hFF);
    rd_chk(ADR_PRI_BASE + 8'h40, 32'h7);
    wb(1'b1, ADR_PRI_BASE + 8'h08, 32'h5);
    rd_chk(ADR_PRI_BASE + 8'h08, 32'h0);
  endtask
  task automatic t_irq();
    wb(1'b1, ADR_ENABLE, 32'h3FFFFFFF);
    wb(1'b1, ADR_PRI_BASE + 8'h40, 32'h5);
    wb(1'b1, ADR_PRI_BASE + 8'h44, 32'h2);
    @(posedge clk);
    {irq, fwait} <= {30'h3, 4'h5};
    take_chk(6'h11);
    @(posedge clk);
    irq <= 30'h0;
    repeat (4) @(posedge clk);
    wb(1'b1, ADR_PEND_CLR, 32'h2);
    rd_chk(ADR_PEND_SET, 32'h1);
    rd_chk(ADR_ACTIVE, 32'h2);
    rd_chk(ADR_STATUS, 32'h00000511);
    retire();
    take_chk(6'h10);
    retire();
  endtask
  task automatic t_nest();
    wb(1'b1, ADR_PRI_BASE + 8'h40, 32'h3);
    wb(1'b1, ADR_PRI_BASE + 8'h44, 32'h3);
    wb(1'b1, ADR_PRI_BASE + 8'h48, 32'h1);
    wb(1'b1, ADR_PEND_SET, 32'h3);
    take_chk(6'h10);
    quiet(20);
    rd_chk(ADR_PEND_SET, 32'h2);
    wb(1'b1, ADR_PEND_SET, 32'h4);
    take_chk(6'h12);
    // NMI goes up two cycles early to cover its synchroniser, so both pend together
    @(posedge clk);
    {nmi, fwait} <= {1'b1, 4'h0};
    repeat (2) @(posedge clk);
    {nmi, hard} <= 2'b01;
    @(posedge clk);
    hard <= 1'b0;
    take_chk(EXC_NMI);
    retire();
    take_chk(EXC_HARD);
    repeat (3) retire();
    take_chk(6'h11);
    retire();
  endtask
  task automatic t_sys();
    wb(1'b1, ADR_PRI_BASE + 8'h2C, 32'h6);
    wb(1'b1, ADR_SYS_PEND, 32'h3);
    ce <= 1'b0; // Freeze mid-fetch: model acks must go unseen
    quiet(10);
    @(posedge clk);
    ce <= 1'b1;
    take_chk(EXC_PENDABLE_SERVICE_REQUEST);
    @(posedge clk);
    svc <= 1'b1;
    @(posedge clk);
    svc <= 1'b0;
    quiet(10);
    retire();
    take_chk(EXC_SYSTICK);
    retire();
    take_chk(EXC_SVC);
    retire();
  endtask
  task automatic t_absent();
    @(posedge clk);
    irq <= 30'h200;
    repeat (6) @(posedge clk);
    rd_chk(ADR_PEND_SET, 32'h0);
    irq <= 30'h0;
    wb(1'b1, ADR_PEND_SET, 32'h200);
    take_chk(6'h19);
    retire();
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    base = 32'h0;
    take_chk(EXC_RESET);
    rd_chk(ADR_VBASE, 32'h0);
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence: five reset cycles, then each scenario in turn
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_base();
    t_irq();
    t_nest();
    t_sys();
    t_absent();
    finish_test();
  end
endmodule
